// ---- design/bpc_pkg.sv ----
// package of constants and types for the buffered port control block
package bpc_pkg;
  localparam int PORT_W = 4;
  localparam int XFER_W = 32;
  localparam int WORDS = XFER_W / PORT_W;
  localparam int CNT_W = 4;
  localparam int BITS_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_FULL = 4'h8;
  localparam logic [1:0] RDY_NONE = 2'h0;
  localparam logic [1:0] RDY_RESET = RDY_NONE;
  localparam logic [PORT_W-1:0] PIN_RESET = 4'h0;
  localparam logic [XFER_W-1:0] WORD_ZERO = 32'h0;

  typedef enum logic [3:0] {
    OP_START,
    OP_STOP,
    OP_PEEK,
    OP_CLEAR,
    OP_SYNC,
    OP_ENDIN,
    OP_IN,
    OP_OUT,
    OP_SETRDY
  } bpc_op_type;
endpackage : bpc_pkg

// ---- design/bpc_port.sv ----
// buffered clocked port: control, serdes, peek, clear, sync and end-input
// Function
// R01 - activation empties the buffer
// R02 - deactivation returns to no-ready mode
// R03 - peek returns one port-width pin sample
// R04 - peek answers at once, bypassing buffering
// R05 - peek leaves all port state unchanged
// R06 - clear discards unread input data
// R07 - clear discards undriven output data
// R08 - clear stops output shifting immediately
// R09 - clear keeps the current direction
// R10 - clear keeps driving current pin value
// R11 - sync stalls until outputs done, held
// R12 - end-input returns count of unread bits; code leaves out a sample shifted in by a tick in the same cycle
// R13 - count covers transfer and shift registers
// R14 - then full words while full words remain
// R15 - last input holds remainder in msbs
// R16 - widths fixed, shift register transfer-wide
`timescale 1ns/1ps
module bpc_port (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic port_tick_i,
  input wire logic cmd_valid_i,
  input wire bpc_pkg::bpc_op_type cmd_op_i,
  input wire logic [bpc_pkg::XFER_W-1:0] cmd_data_i,
  input wire logic [bpc_pkg::PORT_W-1:0] pin_i,
  output logic [bpc_pkg::PORT_W-1:0] pin_o,
  output logic [bpc_pkg::PORT_W-1:0] pin_oe_o,
  output logic busy_o,
  output logic resp_valid_o,
  output logic [bpc_pkg::XFER_W-1:0] resp_data_o,
  output logic active_o,
  output logic [1:0] rdy_mode_o
);
  import bpc_pkg::*;

  function automatic logic [BITS_W-1:0] bit_count(
    input logic full, input logic [CNT_W-1:0] cnt);
    logic [BITS_W-1:0] s;
    s = full ? BITS_W'(XFER_W) : 8'h00;
    bit_count = s + BITS_W'(cnt) * BITS_W'(PORT_W);
  endfunction : bit_count

  // shift register is one transfer wide (see R16)
  logic [XFER_W-1:0] shift_q;
  logic [XFER_W-1:0] xfer_q;
  logic [CNT_W-1:0] cnt_q;
  logic xfer_full_q, xfer_out_q, dir_out_q, ended_q, held_q;
  logic active_q, busy_q;
  logic [1:0] rdy_q;
  bpc_op_type op_q;
  logic [XFER_W-1:0] odata_q;
  logic [PORT_W-1:0] pin_q;
  logic resp_q;
  logic [XFER_W-1:0] rdata_q;

  wire bpc_op_type cur_op = busy_q ? op_q : cmd_op_i;
  wire [XFER_W-1:0] cur_data = busy_q ? odata_q : cmd_data_i;
  wire go = busy_q | cmd_valid_i;
  wire in_full = xfer_full_q & ~xfer_out_q;
  wire in_tail = ended_q & ~dir_out_q & (cnt_q != CNT_ZERO);
  wire out_idle = ~xfer_full_q & (cnt_q == CNT_ZERO);
  // an input port has nothing to drain, so sync must not wait on input data
  wire out_quiet = ~(xfer_full_q & xfer_out_q)
                   & ~(dir_out_q & (cnt_q != CNT_ZERO));
  wire sync_ok = out_quiet & (held_q | ~dir_out_q); // see R11
  wire tick = port_tick_i & active_q;
  wire can_done = (cur_op == OP_IN) ? (in_full | in_tail) :
                  (cur_op == OP_OUT) ? ~xfer_full_q :
                  (cur_op == OP_SYNC) ? sync_ok : 1'b1;
  wire done = go & can_done;
  wire do_clear = done & ((cur_op == OP_CLEAR) | (cur_op == OP_START));
  wire do_in = done & (cur_op == OP_IN);
  wire do_out = done & (cur_op == OP_OUT);
  wire do_endin = done & (cur_op == OP_ENDIN);
  wire sh_out = tick & dir_out_q & (cnt_q != CNT_ZERO);
  wire ld_out = tick & (cnt_q == CNT_ZERO) & xfer_full_q & xfer_out_q;
  wire sh_in = tick & ~dir_out_q & ~ended_q & ~xfer_out_q
               & (cnt_q != CNT_FULL);
  wire [XFER_W-1:0] shift_in = {pin_i, shift_q[XFER_W-1:PORT_W]};
  wire in_wrap = sh_in & (cnt_q == CNT_FULL - 4'h1) & ~xfer_full_q;

  // answer data; peek bypasses every buffer and counter (see R03) (see R04)
  wire [XFER_W-1:0] ans =
    (cur_op == OP_PEEK) ? {{(XFER_W-PORT_W){1'b0}}, pin_i} :
    (cur_op == OP_ENDIN) ?
      {{(XFER_W-BITS_W){1'b0}}, bit_count(in_full, cnt_q)} :
    (cur_op == OP_IN) ? (in_full ? xfer_q : shift_q) : WORD_ZERO;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'b0;
      op_q <= OP_START;
      odata_q <= WORD_ZERO;
      resp_q <= 1'b0;
      rdata_q <= WORD_ZERO;
    end else begin
      busy_q <= go & ~done;
      if (cmd_valid_i & ~busy_q) begin
        op_q <= cmd_op_i;
        odata_q <= cmd_data_i;
      end
      resp_q <= done;
      if (done) begin
        rdata_q <= ans;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      active_q <= 1'b0;
      rdy_q <= RDY_RESET;
    end else if (done & (cur_op == OP_START)) begin
      active_q <= 1'b1;
    end else if (done & (cur_op == OP_STOP)) begin
      active_q <= 1'b0;
      rdy_q <= RDY_NONE; // see R02
    end else if (done & (cur_op == OP_SETRDY)) begin
      rdy_q <= cur_data[1:0];
    end
  end

  // datapath; a peek never reaches this process (see R05)
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      shift_q <= WORD_ZERO;
      xfer_q <= WORD_ZERO;
      cnt_q <= CNT_ZERO;
      xfer_full_q <= 1'b0;
      xfer_out_q <= 1'b0;
      dir_out_q <= 1'b0;
      ended_q <= 1'b0;
      held_q <= 1'b1;
      pin_q <= PIN_RESET;
    end else if (do_clear) begin
      // pin_q and dir_out_q untouched: pins keep value (see R09) (see R10)
      xfer_full_q <= 1'b0; // see R01 (see R06) (see R07)
      xfer_out_q <= 1'b0;
      cnt_q <= CNT_ZERO; // see R08
      ended_q <= 1'b0;
      held_q <= 1'b1;
    end else begin
      if (do_endin) begin
        ended_q <= 1'b1; // see R12 (see R13)
      end
      if (do_in & in_full) begin
        xfer_full_q <= 1'b0; // see R14
        // no partial data left: end-input state ends with the last word
        if (cnt_q == CNT_ZERO) begin
          ended_q <= 1'b0;
        end
      end else if (do_in) begin
        cnt_q <= CNT_ZERO; // see R15
        ended_q <= 1'b0;
      end else if (go & (cur_op == OP_IN) & dir_out_q & out_idle) begin
        // input on an idle output port turns it round, then waits for data
        dir_out_q <= 1'b0;
      end
      if (sh_out) begin
        pin_q <= shift_q[PORT_W-1:0];
        shift_q <= {{PORT_W{1'b0}}, shift_q[XFER_W-1:PORT_W]};
        cnt_q <= cnt_q - 4'h1;
        held_q <= 1'b0;
      end else if (ld_out) begin
        // direction turns to output only here, so a cleared word never flips it
        pin_q <= xfer_q[PORT_W-1:0];
        shift_q <= {{PORT_W{1'b0}}, xfer_q[XFER_W-1:PORT_W]};
        cnt_q <= CNT_FULL - 4'h1;
        dir_out_q <= 1'b1;
        xfer_full_q <= 1'b0;
        xfer_out_q <= 1'b0;
        held_q <= 1'b0;
      end else if (tick & dir_out_q) begin
        held_q <= 1'b1; // last word stood a full port period
      end else if (in_wrap & ~(do_in & in_full)) begin
        xfer_q <= shift_in;
        xfer_full_q <= 1'b1;
        cnt_q <= CNT_ZERO;
      end else if (sh_in & (cnt_q != CNT_FULL - 4'h1)) begin
        shift_q <= shift_in;
        cnt_q <= cnt_q + 4'h1;
      end
      if (do_out) begin
        xfer_q <= cur_data;
        xfer_full_q <= 1'b1;
        xfer_out_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_o <= PIN_RESET;
      pin_oe_o <= PIN_RESET;
    end else begin
      pin_o <= pin_q;
      pin_oe_o <= {PORT_W{dir_out_q & active_q}};
    end
  end

  assign busy_o = busy_q;
  assign resp_valid_o = resp_q;
  assign resp_data_o = rdata_q;
  assign active_o = active_q;
  assign rdy_mode_o = rdy_q;

  a_peek_value: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (cmd_valid_i & ~busy_q & cmd_op_i == OP_PEEK) |=> resp_q
    && rdata_q[PORT_W-1:0] == $past(pin_i)) // see R03
    else $error("peek answer wrong or late");
  a_peek_still: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (done & cur_op == OP_PEEK & ~tick) |=> $stable(cnt_q)
    && $stable(xfer_full_q) && $stable(dir_out_q)) // see R05
    else $error("peek disturbed port state");
  a_clear_empty: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    do_clear |=> cnt_q == CNT_ZERO && !xfer_full_q) // see R06
    else $error("clear left data");
  a_clear_pins: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    do_clear |=> $stable(pin_q) && $stable(dir_out_q)) // see R10
    else $error("clear changed pins or direction");
  a_stop_ready: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (done & cur_op == OP_STOP) |=> rdy_q == RDY_NONE && !active_q) // see R02
    else $error("stop kept ready mode");
  a_sync_wait: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (resp_q & $past(cur_op) == OP_SYNC) |-> $past(out_quiet)
    && ($past(held_q) || !$past(dir_out_q))) // see R11
    else $error("sync released early");
  a_endin_count: assert property (@(posedge core_clk_i)
    disable iff (!rst_b_i)
    do_endin |=> rdata_q[BITS_W-1:0]
    == bit_count($past(in_full), $past(cnt_q))) // see R13
    else $error("end-input count wrong");
  a_start_empty: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
    (done & cur_op == OP_START) |=> active_q && !xfer_full_q
    && !ended_q) // see R01
    else $error("start left buffered data");
endmodule : bpc_port

// ---- bench/bpc_core_model.sv ----
// processor core model issuing port requests
`timescale 1ns/1ps
module bpc_core_model (
  input wire logic clk_i,
  input wire logic busy_i,
  input wire logic resp_valid_i,
  input wire logic [bpc_pkg::XFER_W-1:0] resp_data_i,
  output logic cmd_valid_o,
  output bpc_pkg::bpc_op_type cmd_op_o,
  output logic [bpc_pkg::XFER_W-1:0] cmd_data_o
);
  import bpc_pkg::*;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_op_o = OP_PEEK;
    cmd_data_o = WORD_ZERO;
  end
  // one request at a time; waits for busy low so the request is taken
  task automatic issue(input bpc_op_type op, input logic [XFER_W-1:0] d,
    output logic [XFER_W-1:0] r);
    int n;
    n = 0;
    @(negedge clk_i);
    while (busy_i === 1'b1) begin
      @(negedge clk_i);
    end
    cmd_valid_o = 1'b1;
    cmd_op_o = op;
    cmd_data_o = d;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    // bounded wait: a lost answer comes back unknown and fails any compare
    while (resp_valid_i !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    if (n < 300) begin
      r = resp_data_i;
    end else begin
      r = {XFER_W{1'bx}};
    end
  endtask : issue
endmodule : bpc_core_model

// ---- bench/tb_top.sv ----
// testbench for the buffered port control block
`timescale 1ns/1ps
module tb_top;
  import bpc_pkg::*;
  logic core_clk_i, rst_b_i, port_tick_i, cmd_valid_i, busy_o;
  logic resp_valid_o, active_o;
  bpc_op_type cmd_op_i;
  logic [XFER_W-1:0] cmd_data_i, resp_data_o, r;
  logic [PORT_W-1:0] pin_i, pin_o, pin_oe_o;
  logic [1:0] rdy_mode_o;
  int fails, tests_run;
  bpc_port dut (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .port_tick_i(port_tick_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_op_i(cmd_op_i),
    .cmd_data_i(cmd_data_i),
    .pin_i(pin_i),
    .pin_o(pin_o),
    .pin_oe_o(pin_oe_o),
    .busy_o(busy_o),
    .resp_valid_o(resp_valid_o),
    .resp_data_o(resp_data_o),
    .active_o(active_o),
    .rdy_mode_o(rdy_mode_o)
  );
  bpc_core_model core (.clk_i(core_clk_i), .busy_i(busy_o),
    .resp_valid_i(resp_valid_o), .resp_data_i(resp_data_o),
    .cmd_valid_o(cmd_valid_i), .cmd_op_o(cmd_op_i),
    .cmd_data_o(cmd_data_i));
  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input logic [XFER_W-1:0] g, input logic [XFER_W-1:0] e);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // k port-clock ticks per call, pins settled on return
  task automatic pulse(input int k);
    repeat (k) begin
      @(negedge core_clk_i);
      port_tick_i = 1'b1;
      @(negedge core_clk_i);
      port_tick_i = 1'b0;
      @(negedge core_clk_i);
    end
  endtask : pulse
  task automatic t_dir;
    core.issue(OP_OUT, 32'h1111_1111, r);
    core.issue(OP_CLEAR, WORD_ZERO, r);
    pulse(2);
    chk({28'h0, pin_oe_o}, 32'h0);
    chk({28'h0, pin_o}, 32'h0);
    $display("test dir done");
  endtask : t_dir
  task automatic t_in;
    // start from an empty shift register so the counts below are exact
    core.issue(OP_CLEAR, WORD_ZERO, r);
    pin_i = 4'h5;
    pulse(5);
    pin_i = 4'hA;
    core.issue(OP_PEEK, WORD_ZERO, r);
    chk(r, 32'hA);
    pin_i = 4'h5;
    pulse(5);
    core.issue(OP_ENDIN, WORD_ZERO, r);
    chk(r, 32'h28);
    core.issue(OP_IN, WORD_ZERO, r);
    chk(r, 32'h5555_5555);
    core.issue(OP_IN, WORD_ZERO, r);
    chk({24'h0, r[31:24]}, 32'h55);
    $display("test endin done");
  endtask : t_in
  task automatic t_clr;
    core.issue(OP_START, WORD_ZERO, r);
    pulse(3);
    core.issue(OP_CLEAR, WORD_ZERO, r);
    core.issue(OP_ENDIN, WORD_ZERO, r);
    chk(r, 32'h0);
    core.issue(OP_START, WORD_ZERO, r);
    pulse(9);
    core.issue(OP_START, WORD_ZERO, r);
    core.issue(OP_ENDIN, WORD_ZERO, r);
    chk(r, 32'h0);
    core.issue(OP_START, WORD_ZERO, r);
    $display("test clear done");
  endtask : t_clr
  task automatic t_out;
    core.issue(OP_OUT, 32'h8765_4321, r);
    pulse(2);
    chk({28'h0, pin_o}, 32'h2);
    core.issue(OP_CLEAR, WORD_ZERO, r);
    pulse(3);
    chk({28'h0, pin_o}, 32'h2);
    chk({28'h0, pin_oe_o}, 32'hF);
    // nothing pending after the clear, so sync answers at once
    core.issue(OP_SYNC, WORD_ZERO, r);
    chk(r, WORD_ZERO);
    chk({28'h0, pin_o}, 32'h2);
    core.issue(OP_OUT, 32'h8765_4321, r);
    // ticks keep running while the sync request stalls
    fork
      begin
        core.issue(OP_SYNC, WORD_ZERO, r);
        chk({28'h0, pin_o}, 32'h8);
      end
      pulse(12);
      begin
        repeat (4) @(negedge core_clk_i);
        chk({31'h0, busy_o}, 32'h1);
      end
    join
    chk({28'h0, pin_o}, 32'h8);
    $display("test out done");
  endtask : t_out
  task automatic t_rdy;
    core.issue(OP_SETRDY, 32'h3, r);
    chk({30'h0, rdy_mode_o}, 32'h3);
    chk({31'h0, active_o}, 32'h1);
    core.issue(OP_STOP, WORD_ZERO, r);
    chk({30'h0, rdy_mode_o}, 32'h0);
    chk({31'h0, active_o}, 32'h0);
    $display("test ready done");
  endtask : t_rdy
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    #60000;
    fails++;
    report_and_stop();
  end
  initial begin
    rst_b_i = 1'b0;
    port_tick_i = 1'b0;
    pin_i = PIN_RESET;
    repeat (6) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    core.issue(OP_START, WORD_ZERO, r);
    t_dir();
    t_in();
    t_clr();
    t_out();
    t_rdy();
    report_and_stop();
  end
endmodule : tb_top
